/* attc_pkg.sv */
package attc_pkg;
  localparam int ATTC_CHANNELS = 2;
  localparam logic [3:0] ATTC_OFF_TRIG0 = 4'h0;
  localparam logic [3:0] ATTC_OFF_TRIG1 = 4'h4;
  localparam logic [3:0] ATTC_OFF_STATUS = 4'h8;
  localparam logic [3:0] ATTC_OFF_MASK = 4'hc;
  localparam int ATTC_BIT_START = 0;
  localparam int ATTC_BIT_STOP = 1;
  localparam logic [7:0] ATTC_TRIG_RESET = 8'h00;
  localparam logic [1:0] ATTC_IRQ_RESET = 2'h0;
  localparam logic [4:0] ATTC_ADDR_RESET = 5'h00;
  localparam logic [31:0] ATTC_UNMAPPED = 32'h00000000;
endpackage

/* attc_top.sv */
`timescale 1ns/1ps
`default_nettype none
module attc_top
  import attc_pkg::*;
(
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic rst_n,
  // Avalon-MM slave.
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Per-channel unit controls.
  input wire logic [1:0] auto_transfer_enable,
  // Transfer engine handshake, one bit per channel; engine_addr has five bits per channel.
  output logic [1:0] engine_start,
  output logic [1:0] engine_stop,
  input wire logic [1:0] byte_done,
  input wire logic [1:0] transfer_end,
  input wire logic [9:0] engine_addr,
  // Completion and suspension results.
  output logic [1:0] transfer_done_irq,
  output logic [9:0] suspend_address_capture,
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////
  logic [1:0] start_q;
  logic [1:0] stop_q;
  logic [1:0] status;
  logic [1:0] mask;
  logic ack;
  // Completion is delayed one clock so the trigger bits read zero before
  // the interrupt pulse appears.
  logic [1:0] finish_q;

  wire req = (avs_read | avs_write) & ~ack;
  wire sel_t0 = avs_address == ATTC_OFF_TRIG0;
  wire sel_t1 = avs_address == ATTC_OFF_TRIG1;
  wire sel_st = avs_address == ATTC_OFF_STATUS;
  wire sel_mk = avs_address == ATTC_OFF_MASK;
  // Writes land in the answer cycle, when waitrequest is low.
  wire wr_lane0 = avs_write & ack & avs_byteenable[0];
  // Bit-wise writes land as a byte write with one bit set; a zero in the
  // other bit never cancels a running request, so single-bit use is safe.
  wire [1:0] wr_trig = {wr_lane0 & sel_t1 & auto_transfer_enable[1],
                        wr_lane0 & sel_t0 & auto_transfer_enable[0]};
  wire [1:0] set_start = wr_trig & {2{avs_writedata[ATTC_BIT_START]}};
  wire [1:0] set_stop = wr_trig & {2{avs_writedata[ATTC_BIT_STOP]}};
  wire [1:0] busy = start_q | stop_q;
  // A stop ends at the next byte boundary; a start runs to the end.
  wire [1:0] finish = (stop_q & byte_done) |
                      (start_q & ~stop_q & transfer_end);
  wire [1:0] next_start = (start_q | set_start) & ~finish;
  wire [1:0] next_stop = (stop_q | (set_stop & (start_q | set_start)))
                         & ~finish;
  wire [1:0] clr_st = (wr_lane0 & sel_st) ? avs_writedata[1:0] : 2'h0;
  wire [1:0] next_status = finish_q | (status & ~clr_st);
  wire [7:0] trig0 = {6'h00, stop_q[0], start_q[0]};
  wire [7:0] trig1 = {6'h00, stop_q[1], start_q[1]};
  wire [31:0] next_rdata = sel_t0 ? {24'h000000, trig0} :
                           sel_t1 ? {24'h000000, trig1} :
                           sel_st ? {30'h0, status} :
                           sel_mk ? {30'h0, mask} : ATTC_UNMAPPED;

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      start_q <= ATTC_IRQ_RESET;
      stop_q <= ATTC_IRQ_RESET;
      status <= ATTC_IRQ_RESET;
      mask <= ATTC_IRQ_RESET;
      ack <= 1'b0;
      finish_q <= ATTC_IRQ_RESET;
      engine_start <= ATTC_IRQ_RESET;
      engine_stop <= ATTC_IRQ_RESET;
      avs_waitrequest <= 1'b1;
      avs_readdata <= ATTC_UNMAPPED;
      transfer_done_irq <= ATTC_IRQ_RESET;
      suspend_address_capture <= {ATTC_ADDR_RESET, ATTC_ADDR_RESET};
      irq <= 1'b0;
    end else begin
      start_q <= next_start;
      stop_q <= next_stop;
      status <= next_status;
      if (wr_lane0 & sel_mk) begin
        mask <= avs_writedata[1:0];
      end
      ack <= req;
      avs_waitrequest <= ~req;
      finish_q <= finish;
      engine_start <= next_start & ~next_stop;
      engine_stop <= next_stop;
      if (avs_read & req) begin
        avs_readdata <= next_rdata;
      end
      // Bits clear in the cycle before the pulse, as seen by software.
      transfer_done_irq <= finish_q;
      if (stop_q[0] & byte_done[0]) begin
        suspend_address_capture[4:0] <= engine_addr[4:0];
      end
      if (stop_q[1] & byte_done[1]) begin
        suspend_address_capture[9:5] <= engine_addr[9:5];
      end
      irq <= |(next_status & mask);
    end
  end

endmodule
`default_nettype wire

/* attc_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
module attc_chk(input wire logic ref_clk, rst_n, avs_waitrequest,
  input wire logic [1:0] engine_start, engine_stop, byte_done, transfer_end,
  input wire logic [1:0] transfer_done_irq);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  a_reset_idle: assert property ($rose(rst_n) |-> !engine_start)
    else $error("busy");
  a_stop_halt: assert property (engine_stop[1] && byte_done[1] |=>
    !engine_stop[1] ##1 transfer_done_irq[1]) else $error("stop");
  a_start_end: assert property (engine_start[0] && transfer_end[0] |=>
    !engine_start[0] ##1 transfer_done_irq[0]) else $error("end");
  a_done_pulse0: assert property (transfer_done_irq[0] |=>
    !transfer_done_irq[0]) else $error("pulse0");
  a_done_pulse1: assert property (transfer_done_irq[1] |=>
    !transfer_done_irq[1]) else $error("pulse1");
  cover property (byte_done[1]);
  cover property (transfer_end[0]);
  cover property (!avs_waitrequest);
endmodule
bind attc_top attc_chk u_chk(.*);
`default_nettype wire

/* attc_engine_model.sv */
`timescale 1ns/1ps
`default_nettype none
module attc_engine_model(input wire logic ref_clk, input wire logic [1:0] go,
  output logic [1:0] byte_done, transfer_end, output logic [9:0] engine_addr);
  // A byte takes four clocks, so a stop always lands inside a transfer.
  always_ff @(posedge ref_clk) for (int i = 0; i < 2; i++) begin
    engine_addr[i*5+:5] <= go[i] ? engine_addr[i*5+:5] + 5'h1 : 5'h0;
    byte_done[i] <= go[i] && &engine_addr[i*5+:2];
    transfer_end[i] <= go[i] && &engine_addr[i*5+:4];
  end
endmodule
`default_nettype wire

/* attc_top_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module attc_top_tb;
  logic ref_clk = 0, rst_n = 0, avs_read = 0, avs_write = 0;
  logic avs_waitrequest, irq;
  logic [3:0] avs_address = 4'h0, avs_byteenable = 4'h1;
  logic [31:0] avs_writedata = 32'h0, avs_readdata;
  logic [1:0] auto_transfer_enable = 2'h3, engine_start, engine_stop;
  logic [1:0] byte_done, transfer_end, transfer_done_irq;
  logic [9:0] engine_addr, suspend_address_capture;
  int miscompares = 0, checked = 0, seed = 32'h65ba, m;
  attc_top DUT(.*);
  attc_engine_model u_eng(.ref_clk, .go(engine_start | engine_stop),
    .byte_done, .transfer_end, .engine_addr);
  always #12.5 ref_clk = ~ref_clk;
  task automatic bus(logic [3:0] a, logic w, logic [31:0] v, e = 0);
    @(posedge ref_clk) {avs_address, avs_writedata} <= {a, v};
    {avs_write, avs_read} <= {w, !w};
    @(posedge ref_clk iff !avs_waitrequest) {avs_write, avs_read} <= 2'h0;
    checked += !w;
    if (!w && avs_readdata !== e) begin
      miscompares++; $display("[FAIL] readdata %h %h", e, avs_readdata);
    end
  endtask
  task automatic end_sim;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin repeat (2000) @(posedge ref_clk); miscompares++; end_sim; end
  initial begin
    repeat (20) @(posedge ref_clk);
    rst_n <= 1'b1;
    // Upper bits carry noise that must never read back.
    m = $random(seed) & 32'hfffffffc | 1;
    bus(4'h0, 0, 0); bus(4'hc, 1, 3);
    bus(4'h0, 1, m); bus(4'h0, 0, 0, m & 3);
    @(posedge ref_clk iff irq) bus(4'h8, 0, 0, 1);
    bus(4'h0, 0, 0); bus(4'h8, 1, 1); bus(4'h4, 1, 1); bus(4'h4, 1, 2);
    @(posedge ref_clk iff irq) bus(4'h4, 0, 0);
    checked++;
    if (suspend_address_capture[6:5] !== 2'h0 ||
        suspend_address_capture[9:5] == 5'h0) begin
      miscompares++; $display("[FAIL] capture 00 %h", suspend_address_capture);
    end
    auto_transfer_enable <= 2'h2; bus(4'h4, 1, 2);
    auto_transfer_enable <= 2'h3; bus(4'h4, 0, 0); bus(4'h2, 0, 0);
    end_sim;
  end
endmodule
`default_nettype wire
